// ---- src/timer16_pkg.sv ----
/*
 * Package for the 16-bit timer/event counter control block: register
 * addresses, bit positions, reset values, mode encodings and carrier structs.
 * Assumes a byte-wide register port with a full 16-bit address compare.
 */
package timer16_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [15:0] ADDR_CAPTURE_COMPARE_CONTROL = 16'hff6a;
  localparam logic [15:0] ADDR_TIMER_OUTPUT_CONTROL    = 16'hff6b;
  localparam logic [15:0] ADDR_TIMER_MODE_CONTROL      = 16'hff7e;
  localparam logic [15:0] ADDR_CAPCOMP_ZERO_LO         = 16'hff7a;
  localparam logic [15:0] ADDR_CAPCOMP_ZERO_HI         = 16'hff7b;
  localparam logic [15:0] ADDR_CAPCOMP_ONE_LO          = 16'hff7c;
  localparam logic [15:0] ADDR_CAPCOMP_ONE_HI          = 16'hff7d;
  localparam logic [15:0] ADDR_PRESCALER_EDGE_SELECT   = 16'hff7f;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'hffff;

  // ************************************************************
  // Bit positions
  // ************************************************************
  // Mode register
  localparam int MODE_OVERFLOW_BIT  = 0;
  localparam int MODE_INVERT_SRC    = 1;
  localparam int MODE_RUN_LO        = 2;
  localparam int MODE_RUN_HI        = 3;
  // Capture/compare control
  localparam int CC_ZERO_ROLE       = 0;
  localparam int CC_CAPTURE_SRC     = 1;
  localparam int CC_ONE_ROLE        = 2;
  // Output control
  localparam int OC_OUTPUT_ENABLE   = 0;
  localparam int OC_INVERT_ZERO     = 1;
  localparam int OC_LEVEL_RESET     = 2;
  localparam int OC_LEVEL_SET       = 3;
  localparam int OC_INVERT_ONE      = 4;
  localparam int OC_ONESHOT_MODE    = 5;
  localparam int OC_ONESHOT_TRIGGER = 6;
  // Edge select
  localparam int EDGE_A_LO          = 4;
  localparam int EDGE_A_HI          = 5;
  localparam int EDGE_B_LO          = 6;
  localparam int EDGE_B_HI          = 7;

  // Writable masks (bits outside each mask read as zero)
  localparam logic [7:0] MODE_WMASK = 8'h0f;
  localparam logic [7:0] CC_WMASK   = 8'h07;
  localparam logic [7:0] OC_RMASK   = 8'h33;
  localparam logic [7:0] EDGE_WMASK = 8'hf3;

  // ************************************************************
  // Encodings
  // ************************************************************
  typedef enum logic [1:0] {
    RUN_STOP       = 2'b00,
    RUN_FREE       = 2'b01,
    RUN_EDGE_CLEAR = 2'b10,
    RUN_MATCH_CLR  = 2'b11
  } run_mode_t;

  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b11;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;

  // Pin-side events seen in one cycle
  typedef struct packed {
    logic a_valid;
    logic a_reverse;
    logic b_valid;
  } pin_event_t;

endpackage

// ---- src/timer16_capture_compare_control.sv ----
/*
 * 16-bit timer/event counter with two capture/compare registers, one
 * toggling output and the three control registers that steer them.
 * Assumes a byte register port on the processor side, pins already
 * synchronous to clk, and a count clock equal to clk.
 *
 * The count clock prescaler is not modelled: the counter advances on
 * every clk edge while any running mode is selected. Software is trusted
 * to stop the timer before it rewrites control fields; nothing here
 * blocks such a write, so a mid-run change takes effect at once.
 */
// Overview of operation
// - Nonzero run field starts counter, zero stops
// - Stopped: counter cleared, output held, no irqs
// - Match irq zero and one on compares
// - Mode 10 clears counter on input-a edge
// - Mode 11 clears on match zero; 01 free
// - Output inverts on matches, optionally input-a edge
// - Overflow flag on wrap with compare FFFF
// - Reset clears three control registers to 00
// - Register one role: 0 compare, 1 capture
// - Register zero role: 0 compare, 1 capture
// - Capture source: input b or reverse input a
// - No reverse-a capture when input a uses both edges
// - Writing one trigger bit fires one-shot
// - Pulse mode: 0 successive, 1 one-shot
// - Separate enables for inversion per match
// - Level field forces output; 11 forbidden
// - Output disable holds pin low
// - Input-a edge select: 00 fall, 01 rise, 11 both
// - Trigger bit self-clears, reads zero
// - Level bits read zero
// - One-shot trigger resets counter to 0000
`timescale 1ns/1ps

module timer16_capture_compare_control
  import timer16_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire reg_req_t    reg_req,
  output logic      [7:0]  reg_rdata,
  input  wire logic        timer_in_a,
  input  wire logic        timer_in_b,
  output logic             timer_out_pin,
  output logic             match_irq_zero,
  output logic             match_irq_one
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0]  timer_mode_control;
  logic [7:0]  capture_compare_control;
  logic [7:0]  timer_output_control;
  logic [7:0]  prescaler_edge_select;
  logic [15:0] up_counter;
  logic [15:0] capcomp_zero;
  logic [15:0] capcomp_one;
  logic        out_ff;
  logic        in_a_prev;
  logic        in_b_prev;
  logic        overflow_flag;

  // ************************************************************
  // Decoded controls
  // ************************************************************
  run_mode_t  run_mode;
  logic       running;
  logic       invert_source_sel;
  logic       reg_zero_role;
  logic       reg_one_role;
  logic       capture_source_sel;
  logic       oneshot_mode_sel;
  logic       invert_on_match_zero;
  logic       invert_on_match_one;
  logic       output_enable;
  logic [1:0] in_a_edge;
  logic [1:0] in_b_edge;
  pin_event_t pin_ev;
  logic       match_zero;
  logic       match_one;
  logic       sw_trigger;
  logic       wr_mode;
  logic       wr_cc;
  logic       wr_oc;
  logic       wrap;

  assign run_mode             = run_mode_t'(timer_mode_control[MODE_RUN_HI:MODE_RUN_LO]);
  assign running              = run_mode != RUN_STOP;
  assign invert_source_sel    = timer_mode_control[MODE_INVERT_SRC];
  assign reg_zero_role        = capture_compare_control[CC_ZERO_ROLE];
  assign reg_one_role         = capture_compare_control[CC_ONE_ROLE];
  assign capture_source_sel   = capture_compare_control[CC_CAPTURE_SRC];
  assign oneshot_mode_sel     = timer_output_control[OC_ONESHOT_MODE];
  assign invert_on_match_zero = timer_output_control[OC_INVERT_ZERO];
  assign invert_on_match_one  = timer_output_control[OC_INVERT_ONE];
  assign output_enable        = timer_output_control[OC_OUTPUT_ENABLE];
  assign in_a_edge            = prescaler_edge_select[EDGE_A_HI:EDGE_A_LO];
  assign in_b_edge            = prescaler_edge_select[EDGE_B_HI:EDGE_B_LO];

  assign wr_mode = reg_req.wr && reg_req.addr == ADDR_TIMER_MODE_CONTROL;
  assign wr_cc   = reg_req.wr && reg_req.addr == ADDR_CAPTURE_COMPARE_CONTROL;
  assign wr_oc   = reg_req.wr && reg_req.addr == ADDR_TIMER_OUTPUT_CONTROL;

  // Trigger acts only in one-shot mode; it is never stored
  assign sw_trigger = wr_oc && reg_req.wdata[OC_ONESHOT_TRIGGER] && oneshot_mode_sel;

  // ************************************************************
  // Pin edge detection
  // ************************************************************
  // Valid edge per the two-bit select; the reverse phase feeds capture.
  // Edges are found by comparing the pin with its last clk sample, so a
  // pulse must stand for at least one full clk to be seen at all.
  // The prohibited select 10 matches nothing, so a bad setting is
  // quiet instead of producing spurious clears or captures.
  // Both-edge select has no reverse phase, which is how the register zero capture from
  // the first input is suppressed in that setting.
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur,
                                    input logic reverse);
    logic rise;
    logic fall;
    rise = !prev && cur;
    fall = prev && !cur;
    case (sel)
      EDGE_FALL: edge_hit = reverse ? rise : fall;
      EDGE_RISE: edge_hit = reverse ? fall : rise;
      EDGE_BOTH: edge_hit = reverse ? 1'b0 : (rise || fall);
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  // Previous pin levels; stopped timer tracks pins so no stale edge fires at start
  always_ff @(posedge clk) begin
    if (srst) begin
      in_a_prev <= 1'b0;
      in_b_prev <= 1'b0;
    end else begin
      in_a_prev <= timer_in_a;
      in_b_prev <= timer_in_b;
    end
  end

  always_comb begin
    pin_ev.a_valid   = running && edge_hit(in_a_edge, in_a_prev, timer_in_a, 1'b0);
    pin_ev.a_reverse = running && edge_hit(in_a_edge, in_a_prev, timer_in_a, 1'b1);
    pin_ev.b_valid   = running && edge_hit(in_b_edge, in_b_prev, timer_in_b, 1'b0);
  end

  // ************************************************************
  // Compare matches
  // ************************************************************
  // Only registers in compare role raise matches, only while running.
  // The counter stays on a value for one clk when counting, so each
  // match lasts exactly one cycle; a compare value that the counter
  // never reaches simply never matches.
  // Wrap marks the last count before the natural roll-over.
  assign match_zero = running && !reg_zero_role && up_counter == capcomp_zero;
  assign match_one  = running && !reg_one_role && up_counter == capcomp_one;
  assign wrap       = running && up_counter == COUNT_MAX;

  // ************************************************************
  // Control registers
  // ************************************************************
  // Mode register; overflow bit is handled separately
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_mode_control <= RESET_BYTE;
    end else if (wr_mode) begin
      timer_mode_control <= reg_req.wdata & MODE_WMASK & ~(8'h01 << MODE_OVERFLOW_BIT);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      capture_compare_control <= RESET_BYTE;
    end else if (wr_cc) begin
      capture_compare_control <= reg_req.wdata & CC_WMASK;
    end
  end

  // Level and trigger bits are actions, never held, so they read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_output_control <= RESET_BYTE;
    end else if (wr_oc) begin
      timer_output_control <= reg_req.wdata & OC_RMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prescaler_edge_select <= RESET_BYTE;
    end else if (reg_req.wr && reg_req.addr == ADDR_PRESCALER_EDGE_SELECT) begin
      prescaler_edge_select <= reg_req.wdata & EDGE_WMASK;
    end
  end

  // Overflow flag: hardware set wins over a same-cycle software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      overflow_flag <= 1'b0;
    end else if (wrap && capcomp_zero == COUNT_MAX) begin
      overflow_flag <= 1'b1;
    end else if (wr_mode) begin
      overflow_flag <= reg_req.wdata[MODE_OVERFLOW_BIT];
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************
  // Clears have priority over the increment.
  // Order of the clears: stop, software trigger, input edge, match.
  // A stopped counter is held at zero, so a restart always counts from
  // zero and the first match comes a fixed number of cycles later.
  // The trigger only reaches here in one-shot mode; elsewhere it is
  // dropped at the decode so a stray write cannot restart a period.
  always_ff @(posedge clk) begin
    if (srst) begin
      up_counter <= RESET_WORD;
    end else if (!running) begin
      up_counter <= RESET_WORD;
    end else if (sw_trigger) begin
      up_counter <= RESET_WORD;
    end else if (run_mode == RUN_EDGE_CLEAR && pin_ev.a_valid) begin
      up_counter <= RESET_WORD;
    end else if (run_mode == RUN_MATCH_CLR && match_zero) begin
      up_counter <= RESET_WORD;
    end else begin
      up_counter <= up_counter + 16'h0001;
    end
  end

  // ************************************************************
  // Capture/compare registers
  // ************************************************************
  // Software loads; capture wins when both land in one cycle.
  // Captures only happen while running because the pin events are
  // gated by the run state, so a stopped timer keeps its values.
  // Software loads are byte wide; the two halves may go in any order,
  // but a compare in between sees a half-written value.
  always_ff @(posedge clk) begin
    if (srst) begin
      capcomp_zero <= RESET_WORD;
    end else if (reg_zero_role && (capture_source_sel ? pin_ev.a_reverse : pin_ev.b_valid)) begin
      capcomp_zero <= up_counter;
    end else if (reg_req.wr && reg_req.addr == ADDR_CAPCOMP_ZERO_LO) begin
      capcomp_zero[7:0] <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == ADDR_CAPCOMP_ZERO_HI) begin
      capcomp_zero[15:8] <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      capcomp_one <= RESET_WORD;
    end else if (reg_one_role && pin_ev.a_valid) begin
      capcomp_one <= up_counter;
    end else if (reg_req.wr && reg_req.addr == ADDR_CAPCOMP_ONE_LO) begin
      capcomp_one[7:0] <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == ADDR_CAPCOMP_ONE_HI) begin
      capcomp_one[15:8] <= reg_req.wdata;
    end
  end

  // ************************************************************
  // Output flip-flop
  // ************************************************************
  // Level forcing beats inversion; 11 is ignored as a safe reading of it.
  // The forcing comes straight from the write data, so the level bits
  // never need storage and always read back as zero.
  // Several inversion sources in one cycle still flip the flop once,
  // which keeps the duty cycle predictable when matches coincide.
  always_ff @(posedge clk) begin
    if (srst) begin
      out_ff <= 1'b0;
    end else if (wr_oc && reg_req.wdata[OC_LEVEL_RESET] && !reg_req.wdata[OC_LEVEL_SET]) begin
      out_ff <= 1'b0;
    end else if (wr_oc && reg_req.wdata[OC_LEVEL_SET] && !reg_req.wdata[OC_LEVEL_RESET]) begin
      out_ff <= 1'b1;
    end else if (running) begin
      // Simultaneous sources invert only once
      if ((match_zero && invert_on_match_zero) || (match_one && invert_on_match_one) ||
          (invert_source_sel && pin_ev.a_valid)) begin
        out_ff <= !out_ff;
      end
    end
  end

  // Pin is registered so it comes straight from a flop.
  // This costs one cycle of delay behind the output flip-flop, but it
  // keeps the pin free of glitches from the enable and level decode.
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_out_pin <= 1'b0;
    end else begin
      timer_out_pin <= output_enable && out_ff;
    end
  end

  // ************************************************************
  // Interrupt pulses
  // ************************************************************
  // One-cycle pulses per match; silent while stopped.
  // Registered so that a downstream controller sees clean pulses one
  // cycle after the counter reaches the compare value.
  always_ff @(posedge clk) begin
    if (srst) begin
      match_irq_zero <= 1'b0;
      match_irq_one  <= 1'b0;
    end else begin
      match_irq_zero <= match_zero;
      match_irq_one  <= match_one;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Registered read; unmapped addresses read zero.
  // Data stands until the next read strobe, so a slow host may take it
  // any time later. The overflow flag lives apart from the mode byte
  // so that a hardware set and a software write can be ordered.
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= RESET_BYTE;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_TIMER_MODE_CONTROL:      reg_rdata <= timer_mode_control | {7'h00, overflow_flag};
        ADDR_CAPTURE_COMPARE_CONTROL: reg_rdata <= capture_compare_control;
        ADDR_TIMER_OUTPUT_CONTROL:    reg_rdata <= timer_output_control;
        ADDR_PRESCALER_EDGE_SELECT:   reg_rdata <= prescaler_edge_select;
        ADDR_CAPCOMP_ZERO_LO:         reg_rdata <= capcomp_zero[7:0];
        ADDR_CAPCOMP_ZERO_HI:         reg_rdata <= capcomp_zero[15:8];
        ADDR_CAPCOMP_ONE_LO:          reg_rdata <= capcomp_one[7:0];
        ADDR_CAPCOMP_ONE_HI:          reg_rdata <= capcomp_one[15:8];
        default:                      reg_rdata <= RESET_BYTE;
      endcase
    end
  end

endmodule

// ---- dv/timer16_pin_model.sv ----
/* Far-side model: drives the two timer input pins with clean pulses.
   Assumes the bench requests a pulse with a one-clock fire strobe. */
`timescale 1ns/1ps
module timer16_pin_model (
  input  wire logic clk,
  input  wire logic fire_a,
  input  wire logic fire_b,
  output logic      timer_in_a,
  output logic      timer_in_b
);
  // ****************
  // Pulse shapers
  // ****************
  logic [1:0] left_a = 2'd0;
  logic [1:0] left_b = 2'd0;
  // Three clocks high, so a capture is never marginal
  always_ff @(posedge clk) begin
    left_a <= fire_a ? 2'd3 : left_a - {1'b0, left_a != 2'd0};
    left_b <= fire_b ? 2'd3 : left_b - {1'b0, left_b != 2'd0};
  end
  // Pins idle low between pulses
  assign timer_in_a = left_a != 2'd0;
  assign timer_in_b = left_b != 2'd0;
endmodule

// ---- dv/timer16_checker.sv ----
/* Port checker for the timer control block.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ps
module timer16_checker
  import timer16_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire reg_req_t   reg_req,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       timer_in_a,
  input  wire logic       timer_in_b,
  input  wire logic       timer_out_pin,
  input  wire logic       match_irq_zero,
  input  wire logic       match_irq_one
);
  // ****************
  // Shadow state
  // ****************
  logic [1:0] run_seen;
  logic       oe_seen;
  logic       wr_oc;
  assign wr_oc = reg_req.wr && reg_req.addr == ADDR_TIMER_OUTPUT_CONTROL;
  // Run field as last written; the bus is its only source
  always_ff @(posedge clk) begin
    if (srst) begin
      run_seen <= 2'b00;
    end else if (reg_req.wr && reg_req.addr == ADDR_TIMER_MODE_CONTROL) begin
      run_seen <= reg_req.wdata[MODE_RUN_HI:MODE_RUN_LO];
    end
  end
  // Output enable as last written
  always_ff @(posedge clk) begin
    if (srst) begin
      oe_seen <= 1'b0;
    end else if (wr_oc) begin
      oe_seen <= reg_req.wdata[OC_OUTPUT_ENABLE];
    end
  end
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  chk_reset_clears: assert property ($fell(srst) |->
    (reg_rdata == 8'h00 && !timer_out_pin && !match_irq_zero && !match_irq_one)) else $error("outputs not cleared");
  chk_stop_noirq: assert property ((run_seen == 2'b00)[*2] |=>
    (!match_irq_zero && !match_irq_one)) else $error("match irq while stopped");
  chk_stop_hold: assert property ((run_seen == 2'b00 && !wr_oc)[*4] |=>
    $stable(timer_out_pin)) else $error("output moved while stopped");
  chk_out_off: assert property (!oe_seen |=> !timer_out_pin) else $error("pin high while disabled");
  chk_level_set: assert property (wr_oc && reg_req.wdata[OC_LEVEL_SET:OC_LEVEL_RESET] == 2'b10 &&
    reg_req.wdata[OC_OUTPUT_ENABLE] |-> ##2 timer_out_pin) else $error("level set not seen");
  chk_level_clr: assert property (wr_oc && reg_req.wdata[OC_LEVEL_SET:OC_LEVEL_RESET] == 2'b01
    |-> ##2 !timer_out_pin) else $error("level reset not seen");
  chk_irq_zero_pulse: assert property ($rose(match_irq_zero) |=> !match_irq_zero) else $error("irq zero long");
  chk_irq_one_pulse: assert property (match_irq_one |=> !match_irq_one) else $error("irq one long");
  chk_oc_readzero: assert property (reg_req.rd && reg_req.addr == ADDR_TIMER_OUTPUT_CONTROL |=>
    (reg_rdata[OC_ONESHOT_TRIGGER] == 1'b0 && reg_rdata[OC_LEVEL_SET:OC_LEVEL_RESET] == 2'b00))
    else $error("write-only bits read back");
endmodule
bind timer16_capture_compare_control timer16_checker timer16_checker_i (
  .clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata), .timer_in_a(timer_in_a),
  .timer_in_b(timer_in_b), .timer_out_pin(timer_out_pin), .match_irq_zero(match_irq_zero),
  .match_irq_one(match_irq_one)
);

// ---- dv/timer16_capture_compare_control_tb_top.sv ----
/* Self-checking bench for the timer control block.
   Assumes the pin model on the inputs and the bound port checker. */
`timescale 1ns/1ps
module timer16_capture_compare_control_tb_top
  import timer16_pkg::*;
  ;
  // ****************
  // Signals
  // ****************
  localparam logic [15:0] A_M = ADDR_TIMER_MODE_CONTROL;
  localparam logic [15:0] A_C = ADDR_CAPTURE_COMPARE_CONTROL;
  localparam logic [15:0] A_O = ADDR_TIMER_OUTPUT_CONTROL;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  reg_req_t   req = '0;
  logic [7:0] rdata;
  logic       fire_a = 1'b0;
  logic       fire_b = 1'b0;
  logic       in_a;
  logic       in_b;
  logic       out_pin;
  logic       irq0;
  logic       irq1;
  logic       last_pin;
  int         failures = 0;
  int         n_checks = 0;
  int         cycles = 0;
  int         n_irq;
  int         n_irq1;
  int         n_tog;
  logic [7:0] d;
  int         n;
  timer16_capture_compare_control timer16_capture_compare_control_i (
    .clk(clk), .srst(srst), .reg_req(req), .reg_rdata(rdata), .timer_in_a(in_a), .timer_in_b(in_b),
    .timer_out_pin(out_pin), .match_irq_zero(irq0), .match_irq_one(irq1)
  );
  timer16_pin_model timer16_pin_model_i (
    .clk(clk), .fire_a(fire_a), .fire_b(fire_b), .timer_in_a(in_a), .timer_in_b(in_b)
  );
  // Clock and hang guard; the overflow case alone needs 65k cycles
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failures = failures + 1;
      give_verdict();
    end
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask
  // Stop writes mode 00; some mode and output control writes come while running
  task automatic stop();
    wr(A_M, 8'h00);
  endtask
  task automatic setcc(input logic [15:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 16'h1, v[15:8]);
  endtask
  task automatic clr();
    n_irq = 0;
    n_irq1 = 0;
    n_tog = 0;
    last_pin = out_pin;
  endtask
  task automatic tick(input int k, input logic fa, input logic fb);
    repeat (k) begin
      @(posedge clk);
      fire_a <= fa;
      fire_b <= fb;
      #1;
      n_irq += int'(irq0 === 1'b1);
      n_irq1 += int'(irq1 === 1'b1);
      n_tog += int'(out_pin !== last_pin);
      last_pin = out_pin;
    end
  endtask
  // Cycles from the call of the task to an irq; 40 means none came
  task automatic wait_on(input logic which);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (n < 40 && (which ? irq1 : irq0) !== 1'b1);
  endtask
  // Capture run: counter well past the compare values before the pulse
  task automatic cap_run(input logic [7:0] cc, input logic [7:0] es, input logic fa, input logic fb);
    setcc(ADDR_CAPCOMP_ZERO_LO, 16'h0003);
    wr(ADDR_PRESCALER_EDGE_SELECT, es);
    wr(A_C, cc);
    wr(A_M, 8'h04);
    clr();
    tick(12, 1'b0, 1'b0);
    tick(1, fa, fb);
    tick(6, 1'b0, 1'b0);
    stop();
    rd(ADDR_CAPCOMP_ZERO_LO);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    logic [15:0] adr [4];
    adr = '{A_M, A_C, A_O, 16'hff00};
    foreach (adr[i]) begin
      rd(adr[i]);
      check("reset value", {8'h00, d}, 16'h0000);
    end
    wait_on(1'b0);
    check("stopped irq", 16'(n), 16'd40);
    wr(A_C, 8'hff);
    rd(A_C);
    check("cc bits", {8'h00, d}, 16'h0007);
    wr(A_O, 8'h74);
    rd(A_O);
    check("oc bits", {8'h00, d}, 16'h0030);
    wr(A_C, 8'h00);
    wr(A_O, 8'h00);
  endtask
  task automatic t_compare();
    logic [7:0] mode [4];
    int         dly [4];
    mode = '{8'h04, 8'h04, 8'h0c, 8'h0c};
    dly = '{4, 40, 4, 4};
    setcc(ADDR_CAPCOMP_ZERO_LO, 16'h0003);
    setcc(ADDR_CAPCOMP_ONE_LO, 16'h0005);
    wr(A_M, 8'h04);
    wait_on(1'b1);
    check("irq one delay", 16'(n), 16'd6);
    for (int i = 0; i < 4; i++) begin
      if (i % 2 == 0) begin
        stop();
        wr(A_M, mode[i]);
      end
      wait_on(1'b0);
      check("irq zero delay", 16'(n), 16'(dly[i]));
    end
    stop();
  endtask
  task automatic t_toggle();
    logic [7:0] ocv [4];
    logic       pin [4];
    ocv = '{8'h09, 8'h05, 8'h09, 8'h00};
    pin = '{1'b1, 1'b0, 1'b1, 1'b0};
    setcc(ADDR_CAPCOMP_ONE_LO, 16'h0001);
    wr(A_O, 8'h01);
    wr(A_O, 8'h03);
    wr(A_M, 8'h0c);
    tick(8, 1'b0, 1'b0);
    clr();
    tick(32, 1'b0, 1'b0);
    check("toggles zero", 16'(n_tog), 16'd8);
    wr(A_O, 8'h13);
    tick(8, 1'b0, 1'b0);
    clr();
    tick(32, 1'b0, 1'b0);
    check("toggles both", 16'(n_tog), 16'd16);
    stop();
    foreach (ocv[i]) begin
      wr(A_O, ocv[i]);
      tick(2, 1'b0, 1'b0);
      check("pin level", {15'h0, out_pin}, {15'h0, pin[i]});
    end
  endtask
  task automatic t_edge();
    logic [7:0] es [3];
    int         tog [3];
    es = '{8'h10, 8'h00, 8'h30};
    tog = '{10, 10, 20};
    setcc(ADDR_CAPCOMP_ZERO_LO, 16'h0008);
    wr(A_O, 8'h01);
    foreach (es[i]) begin
      stop();
      wr(ADDR_PRESCALER_EDGE_SELECT, es[i]);
      wr(A_M, 8'h0a);
      clr();
      repeat (10) begin
        tick(1, 1'b1, 1'b0);
        tick(3, 1'b0, 1'b0);
      end
      tick(4, 1'b0, 1'b0);
      check("edge toggles", 16'(n_tog), 16'(tog[i]));
      check("edge clear", 16'(n_irq), 16'd0);
    end
    stop();
  endtask
  task automatic t_capture();
    cap_run(8'h07, 8'h30, 1'b1, 1'b0);
    check("no capture both edges", {8'h00, d}, 16'h0003);
    check("capture mutes irqs", 16'(n_irq + n_irq1), 16'd0);
    rd(ADDR_CAPCOMP_ONE_LO);
    check("one captured", {8'h00, d}, 16'h0011);
    cap_run(8'h03, 8'h10, 1'b1, 1'b0);
    check("reverse phase capture", {8'h00, d}, 16'h0011);
    cap_run(8'h01, 8'h10, 1'b0, 1'b1);
    check("input b capture", {8'h00, d}, 16'h0011);
    wr(A_C, 8'h00);
  endtask
  task automatic t_oneshot();
    setcc(ADDR_CAPCOMP_ZERO_LO, 16'h0003);
    wr(A_O, 8'h20);
    wr(A_M, 8'h04);
    tick(10, 1'b0, 1'b0);
    wr(A_O, 8'h60);
    wait_on(1'b0);
    check("oneshot restart", 16'(n), 16'd4);
    wr(A_O, 8'h20);
    wait_on(1'b0);
    check("no trigger", 16'(n), 16'd40);
    stop();
    setcc(ADDR_CAPCOMP_ZERO_LO, 16'hffff);
    wr(A_M, 8'h04);
    tick(65545, 1'b0, 1'b0);
    rd(A_M);
    check("overflow set", {8'h00, d}, 16'h0005);
    wr(A_M, 8'h04);
    rd(A_M);
    check("overflow cleared", {8'h00, d}, 16'h0004);
    stop();
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_compare();
    t_toggle();
    t_edge();
    t_capture();
    t_oneshot();
    give_verdict();
  end
endmodule
